// *** logic/brc_top.sv ***
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module brc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Host link pins
  input wire logic burst_clk,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  output logic [15:0] d_out,
  output logic d_oe,
  // Word source from the array side
  input wire logic [15:0] src_data,
  input wire logic src_valid,
  output logic src_ready
);

  // ============================================================
  // Helpers
  function automatic logic brc_hit(input logic [15:0] addr, input logic [15:0] off);
    brc_hit = (addr[15:2] == off[15:2]);
  endfunction : brc_hit

  function automatic logic [10:0] brc_words(input logic [3:0] len, input logic hold);
    logic [3:0] l;
    l = (len > brc_pkg::LEN_MAX) ? brc_pkg::LEN_MAX : len;
    if (hold)
      brc_words = (l == 4'h0) ? 11'h001 : (11'h001 << (l - 4'h1));
    else
      brc_words = 11'h001 << l;
  endfunction : brc_words

  // ============================================================
  // Declarations
  logic [2:0] pins_s;
  logic clk_prev;
  logic rise;
  logic fall;
  logic strobes_on;
  logic ack;
  logic next_ack;
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic [31:0] next_rdata;
  logic under;
  logic next_under;
  logic req;
  logic wr_take;
  brc_pkg::brc_state_t state;
  brc_pkg::brc_state_t next_state;
  logic [4:0] lat_cnt;
  logic [4:0] next_lat_cnt;
  logic [10:0] rem;
  logic [10:0] next_rem;
  logic hold_ph;
  logic next_hold_ph;
  logic [15:0] next_d_out;
  logic load_word;
  logic samp;
  logic [4:0] lat_tgt;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_full;
  logic fifo_empty;
  logic cfg_en;
  logic cfg_edge;
  logic cfg_hold;

  assign cfg_en = cfg[brc_pkg::EN_BIT];
  assign cfg_edge = cfg[brc_pkg::EDGE_BIT];
  assign cfg_hold = cfg[brc_pkg::HOLD_BIT];

  // ============================================================
  // Pin sampling and clock edges
  brc_sync #(.WIDTH(3)) u_sync (
    .clk(ref_clk),
    .arst_n(arst_n),
    .din({burst_clk, chip_sel_n, out_en_n}),
    .dout(pins_s)
  );

  // Previous burst clock level
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      clk_prev <= 1'b1;
    else
      clk_prev <= pins_s[2];
  end

  assign rise = cfg_en && pins_s[2] && !clk_prev;
  assign fall = cfg_en && !pins_s[2] && clk_prev;
  assign strobes_on = !pins_s[1] && !pins_s[0];

  // ============================================================
  // Avalon-MM register slave, one wait state
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  assign wr_take = avs_write && ack;

  // Register next values
  always_comb
  begin
    next_ack = req && !ack;
    next_cfg = cfg;
    next_under = under;
    next_rdata = avs_readdata;
    if (wr_take && brc_hit(avs_address, brc_pkg::CFG_OFFSET))
    begin
      if (avs_byteenable[0])
        next_cfg[7:0] = avs_writedata[7:0] & brc_pkg::CFG_WMASK[7:0];
      if (avs_byteenable[1])
        next_cfg[15:8] = avs_writedata[15:8] & brc_pkg::CFG_WMASK[15:8];
    end
    if (wr_take && avs_byteenable[0] && brc_hit(avs_address, brc_pkg::STAT_OFFSET)
        && avs_writedata[brc_pkg::ST_UNDER_BIT])
      next_under = 1'b0;
    // Underrun set wins over clear
    if (load_word && !fifo_valid)
      next_under = 1'b1;
    if (avs_read && !ack)
    begin
      next_rdata = 32'h0000_0000;
      if (brc_hit(avs_address, brc_pkg::CFG_OFFSET))
        next_rdata[15:0] = cfg;
      else if (brc_hit(avs_address, brc_pkg::STAT_OFFSET))
      begin
        next_rdata[brc_pkg::ST_BUSY_BIT] = (state != brc_pkg::BRC_IDLE);
        next_rdata[brc_pkg::ST_UNDER_BIT] = under;
        next_rdata[brc_pkg::ST_EMPTY_BIT] = fifo_empty;
        next_rdata[brc_pkg::ST_FULL_BIT] = fifo_full;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack <= 1'b0;
      cfg <= brc_pkg::CFG_RESET;
      under <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      cfg <= next_cfg;
      under <= next_under;
      avs_readdata <= next_rdata;
    end
  end

  // ============================================================
  // Word buffer between array side and link
  brc_fifo #(.WIDTH(brc_pkg::DATA_W), .DEPTH(brc_pkg::FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .arst_n(arst_n),
    .wr_data(src_data),
    .wr_valid(src_valid),
    .wr_ready(src_ready),
    .rd_data(fifo_data),
    .rd_valid(fifo_valid),
    .rd_ready(load_word),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // ============================================================
  // Burst sequencer
  // start sampled on falling edge if EDGE_BIT set, else on rising edge
  assign samp = cfg_edge ? fall : rise;
  assign lat_tgt = brc_pkg::LAT_BASE + {1'b0, cfg[brc_pkg::LAT_LSB +: 4]} + {4'h0, cfg_edge};

  // Sequencer next values
  always_comb
  begin
    next_state = state;
    next_lat_cnt = lat_cnt;
    next_rem = rem;
    next_hold_ph = hold_ph;
    load_word = 1'b0;
    case (state)
      brc_pkg::BRC_IDLE:
      begin
        if (samp && strobes_on)
        begin
          next_state = brc_pkg::BRC_LATENCY;
          next_lat_cnt = 5'h00;
        end
      end
      brc_pkg::BRC_LATENCY:
      begin
        if (rise)
        begin
          next_lat_cnt = lat_cnt + 5'h01;
          if (next_lat_cnt == lat_tgt)
          begin
            load_word = 1'b1;
            next_state = brc_pkg::BRC_DATA;
            next_hold_ph = 1'b0;
            next_rem = brc_words(cfg[brc_pkg::LEN_LSB +: 4], cfg_hold) - 11'h001;
          end
        end
      end
      brc_pkg::BRC_DATA:
      begin
        if (rise)
        begin
          if (cfg_hold && !hold_ph)
            next_hold_ph = 1'b1;
          else if (rem == 11'h000)
            next_state = brc_pkg::BRC_IDLE;
          else
          begin
            load_word = 1'b1;
            next_rem = rem - 11'h001;
            next_hold_ph = 1'b0;
          end
        end
      end
      default:
        next_state = brc_pkg::BRC_IDLE;
    endcase
    if (state != brc_pkg::BRC_IDLE && (!strobes_on || !cfg_en))
    begin
      next_state = brc_pkg::BRC_IDLE;
      load_word = 1'b0;
    end
  end

  // Output word, kept on underrun
  always_comb
  begin
    next_d_out = d_out;
    if (load_word && fifo_valid)
      next_d_out = fifo_data;
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= brc_pkg::BRC_IDLE;
      lat_cnt <= 5'h00;
      rem <= 11'h000;
      hold_ph <= 1'b0;
      d_out <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      lat_cnt <= next_lat_cnt;
      rem <= next_rem;
      hold_ph <= next_hold_ph;
      d_out <= next_d_out;
    end
  end

  assign d_oe = (state == brc_pkg::BRC_DATA) && strobes_on;

  // ============================================================
  // Checks
  logic [4:0] rises_seen;
  logic [10:0] loads_seen;
  logic boot_done;

  // Helper counters for checks
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rises_seen <= 5'h00;
      loads_seen <= 11'h000;
      boot_done <= 1'b0;
    end
    else
    begin
      boot_done <= 1'b1;
      if (state == brc_pkg::BRC_IDLE)
        rises_seen <= 5'h00;
      else if (rise && rises_seen != 5'h1F)
        rises_seen <= rises_seen + 5'h01;
      if (state == brc_pkg::BRC_IDLE)
        loads_seen <= 11'h000;
      else if (load_word)
        loads_seen <= loads_seen + 11'h001;
    end
  end

  sequence s_start;
    state == brc_pkg::BRC_IDLE && next_state == brc_pkg::BRC_LATENCY;
  endsequence
  sequence s_first_load;
    state == brc_pkg::BRC_LATENCY && next_state == brc_pkg::BRC_DATA;
  endsequence
  sequence s_normal_end;
    state == brc_pkg::BRC_DATA && rise && strobes_on && cfg_en && next_state == brc_pkg::BRC_IDLE;
  endsequence

  property p_off_idle;
    @(posedge ref_clk) disable iff (!arst_n) !cfg_en |=> state == brc_pkg::BRC_IDLE && !d_oe;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("burst active while disabled");
  property p_rise_start;
    @(posedge ref_clk) disable iff (!arst_n) s_start and (!cfg_edge) |-> rise && strobes_on;
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("start not on rising edge");
  property p_fall_start;
    @(posedge ref_clk) disable iff (!arst_n) s_start and cfg_edge |-> fall && strobes_on;
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("start not on falling edge");
  property p_latency;
    @(posedge ref_clk) disable iff (!arst_n) s_first_load |-> rise && (rises_seen + 5'h01) == lat_tgt;
  endproperty
  a_latency: assert property (p_latency) else $error("first word at wrong clock");
  property p_hold_gap;
    @(posedge ref_clk) disable iff (!arst_n)
      (state == brc_pkg::BRC_DATA && load_word) |-> cfg_hold ? hold_ph : !hold_ph;
  endproperty
  a_hold_gap: assert property (p_hold_gap) else $error("word held wrong number of clocks");
  property p_first_twice;
    @(posedge ref_clk) disable iff (!arst_n)
      (state == brc_pkg::BRC_DATA && cfg_hold && !hold_ph && loads_seen == 11'h001
        && rise && strobes_on) |-> !load_word;
  endproperty
  a_first_twice: assert property (p_first_twice) else $error("first word not held twice");
  property p_length;
    @(posedge ref_clk) disable iff (!arst_n)
      s_normal_end |-> loads_seen == brc_words(cfg[brc_pkg::LEN_LSB +: 4], cfg_hold);
  endproperty
  a_length: assert property (p_length) else $error("burst length mismatch");
  property p_reserved;
    @(posedge ref_clk) disable iff (!arst_n)
      (avs_read && !avs_waitrequest && brc_hit(avs_address, brc_pkg::CFG_OFFSET)) |-> avs_readdata[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  property p_reset_zero;
    @(posedge ref_clk) disable iff (!arst_n) !boot_done |-> cfg == 16'h0000 && state == brc_pkg::BRC_IDLE;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

endmodule : brc_top

// *** logic/brc_pkg.sv ***
// ============================================================
package brc_pkg;

  // ============================================================
  // Register map (byte addresses)
  localparam logic [15:0] CFG_OFFSET = 16'h101C;
  localparam logic [15:0] STAT_OFFSET = 16'h1020;

  // ============================================================
  // Config register fields
  localparam int EN_BIT = 0;
  localparam int EDGE_BIT = 1;
  localparam int HOLD_BIT = 2;
  localparam int LAT_LSB = 8;
  localparam int LEN_LSB = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'hFF07;
  localparam logic [3:0] LEN_MAX = 4'hA;

  // ============================================================
  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_UNDER_BIT = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_FULL_BIT = 3;

  // ============================================================
  // Data path sizes
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int WORDS_W = 11;
  localparam logic [4:0] LAT_BASE = 5'h01;

  // ============================================================
  // Burst sequencer states
  typedef enum logic [1:0] {
    BRC_IDLE,
    BRC_LATENCY,
    BRC_DATA
  } brc_state_t;

endpackage : brc_pkg

// *** logic/brc_sync.sv ***
`timescale 1ns/1ps
module brc_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Async inputs and synced outputs
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // Two flip-flop synchroniser, idles high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '1;
      dout <= '1;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule : brc_sync

// *** logic/brc_fifo.sv ***
`timescale 1ns/1ps
module brc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Read side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // Levels
  output logic full,
  output logic empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // Flags and handshakes
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rd_ptr[AW-1:0]];
  assign push = wr_valid && !full;
  assign pop = rd_ready && !empty;

  // Pointer next values
  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage array
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= wr_data;
    end
  end

endmodule : brc_fifo

// *** bench/brc_host_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Host side: burst clock, strobes and capture of data pins
module brc_host_model (
  // Host link pins
  output logic burst_clk,
  output logic chip_sel_n,
  output logic out_en_n,
  // Data pins as seen by the host
  input wire logic [15:0] d_out,
  input wire logic d_oe
);
  logic [15:0] dat [64];
  logic oe [64];

  // Clock stands low, strobes high outside frames
  initial
  begin
    burst_clk = 1'h0;
    chip_sel_n = 1'h1;
    out_en_n = 1'h1;
  end

  // every read is a burst
  // Samples pins just before each rise; strobes rise at rise stop
  task run(input int nr, input int stop);
    // Keep pin changes off the system clock edge
    #10;
    chip_sel_n = 1'h0;
    out_en_n = 1'h0;
    for (int i = 0; i < nr; i++)
    begin
      #199;
      // Released data pins read back as the inverse
      dat[i] = d_oe ? d_out : ~d_out;
      oe[i] = d_oe;
      if (i == stop)
      begin
        chip_sel_n = 1'h1;
        out_en_n = 1'h1;
      end
      #1;
      burst_clk = 1'h1;
      #200;
      burst_clk = 1'h0;
    end
    #200;
    chip_sel_n = 1'h1;
    out_en_n = 1'h1;
  endtask : run
endmodule : brc_host_model

// *** bench/burst_read_control_bench.sv ***
`timescale 1ns/1ps
// ============================================================
// Bench: register tasks, burst tests, verdict
module burst_read_control_bench;
  localparam logic [15:0] CFG = brc_pkg::CFG_OFFSET;
  localparam logic [15:0] STAT = brc_pkg::STAT_OFFSET;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic burst_clk, chip_sel_n, out_en_n, d_oe, src_ready;
  logic [15:0] d_out;
  logic [15:0] src_data = 16'h0000;
  logic src_valid = 1'h1;
  logic [15:0] exp_w = 16'h0000;
  logic [31:0] r;
  int n_fail = 0;
  int tests_run = 0;

  brc_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .burst_clk(burst_clk),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .d_out(d_out), .d_oe(d_oe),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready));
  brc_host_model host (.burst_clk(burst_clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .d_out(d_out), .d_oe(d_oe));

  // Clock 50 ns
  always #25 ref_clk = ~ref_clk;

  // Source offers a counting word stream, none taken in reset
  always @(posedge ref_clk)
    if (arst_n && src_valid && src_ready)
      src_data <= src_data + 16'h0001;

  // Verdict and end of run
  task conclude;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Compare seen with expected
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One Avalon access, held until waitrequest low
  task av(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    for (k = 0; k < 20; k++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'h0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (k == 20)
    begin
      chk("waitrequest", 32'h1, 32'h0);
      conclude;
    end
  endtask : av

  // Poll status until the buffer refuses more words
  task wait_full;
    int k;
    for (k = 0; k < 40; k++)
    begin
      av(1'h0, STAT, 32'h0, r);
      if (r[3] === 1'h1)
        break;
    end
    chk("fifo_full", {31'h0, r[3]}, 32'h1);
    chk("src_ready", {31'h0, src_ready}, 32'h0);
  endtask : wait_full

  // One full burst checked rise by rise
  task burst(input logic [3:0] len, input logic [3:0] lat, input logic hold, input logic es);
    int first, nw, span;
    first = 2 + lat + es;
    nw = hold ? ((len == 0) ? 1 : (1 << (len - 1))) : (1 << len);
    span = nw << hold;
    wait_full;
    av(1'h1, CFG, {16'h0000, len, lat, 5'h00, hold, es, 1'h1}, r);
    host.run(first + span + 1, 99);
    for (int i = 0; i < first + span + 1; i++)
    begin
      chk("d_oe", {31'h0, host.oe[i]}, (i >= first && i < first + span) ? 32'h1 : 32'h0);
      if (i >= first && i < first + span)
        chk("d_out", {16'h0000, host.dat[i]}, {16'h0000, exp_w + 16'((i - first) >> hold)});
    end
    exp_w = exp_w + 16'(nw);
    $display("burst len %0d lat %0d hold %0d edge %0d done", len, lat, hold, es);
  endtask : burst

  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'h1;
    av(1'h0, CFG, 32'h0, r);
    chk("cfg_reset", r, 32'h0);
    host.run(6, 99);
    for (int i = 0; i < 6; i++)
      chk("d_oe_off", {31'h0, host.oe[i]}, 32'h0);
    $display("reset and disabled test done");
    // Reserved bits, unmapped place
    av(1'h1, CFG, 32'h0000A0FE, r);
    av(1'h1, 16'h2000, 32'hFFFFFFFF, r);
    av(1'h0, CFG, 32'h0, r);
    chk("cfg_mask", r, 32'h0000A006);
    av(1'h0, 16'h2000, 32'h0, r);
    chk("unmapped", r, 32'h0);
    $display("register test done");
    burst(4'h1, 4'h0, 1'h0, 1'h0);
    burst(4'h3, 4'h2, 1'h0, 1'h1);
    burst(4'h2, 4'hF, 1'h1, 1'h0);
    burst(4'h0, 4'h1, 1'h1, 1'h1);
    burst(4'h4, 4'h0, 1'h0, 1'h0);
    // Source stalls: buffer drains, underrun flagged
    wait_full;
    src_valid <= 1'h0;
    av(1'h1, CFG, 32'h00004001, r);
    host.run(20, 99);
    chk("first_word", {16'h0000, host.dat[2]}, {16'h0000, exp_w});
    av(1'h0, STAT, 32'h0, r);
    chk("underrun_empty", {30'h0, r[2:1]}, 32'h3);
    av(1'h1, STAT, 32'h2, r);
    av(1'h0, STAT, 32'h0, r);
    chk("underrun_clear", {31'h0, r[1]}, 32'h0);
    $display("underrun test done");
    // Strobes rise mid-burst: data pins released
    src_valid <= 1'h1;
    wait_full;
    host.run(12, 5);
    chk("abort_oe_before", {31'h0, host.oe[4]}, 32'h1);
    for (int i = 6; i < 12; i++)
      chk("abort_oe", {31'h0, host.oe[i]}, 32'h0);
    av(1'h0, STAT, 32'h0, r);
    chk("abort_busy", {31'h0, r[0]}, 32'h0);
    $display("abort test done");
    conclude;
  end
endmodule : burst_read_control_bench
